// [core/mfr_pkg.sv]
/*
 * Shared constants and types of the multiplexed flash host read port.
 * Assumes a 100 MHz core clock that samples every host pin.
 */
package mfr_pkg;

    localparam int WORD_W = 16;

    // Burst latency figures, in burst clock cycles
    localparam logic [2:0] LAT_RESET = 3'h4;
    localparam logic [2:0] LAT_MIN = 3'h3;
    localparam logic [2:0] LAT_MAX = 3'h7;

    // Burst length select codes
    localparam logic [2:0] BLEN_CONT = 3'h0;
    localparam logic [2:0] BLEN_4 = 3'h1;
    localparam logic [2:0] BLEN_8 = 3'h2;
    localparam logic [2:0] BLEN_16 = 3'h3;
    localparam logic [2:0] BLEN_32 = 3'h4;

    // Pin synchroniser layout and idle values after reset
    localparam int SYNC_W = 22;
    localparam int POS_DATA = 0;
    localparam int POS_CLK = 16;
    localparam int POS_HRST = 17;
    localparam int POS_ADV = 18;
    localparam int POS_WE = 19;
    localparam int POS_OE = 20;
    localparam int POS_CE = 21;
    localparam logic [21:0] SYNC_RESET = 22'h3EFFFF;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ASYNC = 2'b01,
        ST_LAT = 2'b10,
        ST_BURST = 2'b11
    } mfr_state_type;

endpackage : mfr_pkg

// [core/mfr_sync.sv]
/*
 * Two-stage synchroniser for a group of pin levels.
 * Assumes each bit is a level from outside the core clock domain.
 */
`timescale 1ns/100ps

module mfr_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            stage1_r <= RST_VAL;
            stage2_r <= RST_VAL;
        end else begin
            stage1_r <= i_async;
            stage2_r <= stage1_r;
        end
    end

    assign o_sync = stage2_r;

endmodule : mfr_sync

// [core/mfr_read_port.sv]
/*
 * Device-side read logic of a multiplexed address/data flash port:
 * asynchronous reads, clocked linear and wrapping bursts, ready pulse.
 * Assumes an array read port on the core clock answering one cycle
 * after the address, and configuration levels from the device's own
 * register file. The burst clock is sampled, not used as a clock.
 */
`timescale 1ns/100ps

// Overview of operation
// - Async read: latch address, drive addressed word
// - Read mode select enables clocked bursts
// - Fixed bursts wrap inside aligned length
// - Each later clock edge advances the address
// - First word output asynchronously, ignoring latency
// - Latency resets to four, accepts three to seven
// - First burst data at latency plus one edge
// - Ready pulse marks the first burst word
// - Clocked access in async mode still reads
// - Chip select, resets or write end bursts
// - Continuous burst runs sequentially, wraps at top
// - Data lines float when deselected or disabled
// - Hard reset holds device idle with data lines floating while active
module mfr_read_port #(
    parameter int ADDR_W = 16
) (
    input wire logic I_CLOCK,
    input wire logic I_SRST,
    input wire logic i_chip_select_n,
    input wire logic i_output_enable_n,
    input wire logic i_write_strobe_n,
    input wire logic i_address_valid_strobe_n,
    input wire logic i_hard_reset_n,
    input wire logic i_burst_clock,
    input wire logic [mfr_pkg::WORD_W-1:0] i_data_lines,
    input wire logic i_read_mode_select,
    input wire logic [2:0] i_burst_latency_cycles,
    input wire logic [2:0] i_burst_length_select,
    input wire logic i_soft_reset,
    input wire logic [mfr_pkg::WORD_W-1:0] i_mem_data,
    output logic [ADDR_W-1:0] o_mem_addr,
    output logic [mfr_pkg::WORD_W-1:0] o_data_lines,
    output logic o_data_lines_oe,
    output logic o_data_valid_flag
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation

    logic [mfr_pkg::SYNC_W-1:0] pins_s;
    logic ce_n_s;
    logic oe_n_s;
    logic we_n_s;
    logic adv_n_s;
    logic hrst_n_s;
    logic bclk_s;
    logic [mfr_pkg::WORD_W-1:0] dq_s;
    logic bclk_d_r;
    logic bclk_rise;

    mfr_sync #(
        .WIDTH(mfr_pkg::SYNC_W),
        .RST_VAL(mfr_pkg::SYNC_RESET)
    ) u_sync (
        .i_clock(I_CLOCK),
        .i_srst(I_SRST),
        .i_async({i_chip_select_n, i_output_enable_n, i_write_strobe_n,
                  i_address_valid_strobe_n, i_hard_reset_n, i_burst_clock,
                  i_data_lines}),
        .o_sync(pins_s)
    );

    assign ce_n_s = pins_s[mfr_pkg::POS_CE];
    assign oe_n_s = pins_s[mfr_pkg::POS_OE];
    assign we_n_s = pins_s[mfr_pkg::POS_WE];
    assign adv_n_s = pins_s[mfr_pkg::POS_ADV];
    assign hrst_n_s = pins_s[mfr_pkg::POS_HRST];
    assign bclk_s = pins_s[mfr_pkg::POS_CLK];
    assign dq_s = pins_s[mfr_pkg::POS_DATA +: mfr_pkg::WORD_W];

    // Burst clock edge detection on the synchronised level
    always_ff @(posedge I_CLOCK) begin
        if (I_SRST) begin
            bclk_d_r <= 1'b0;
        end else begin
            bclk_d_r <= bclk_s;
        end
    end

    assign bclk_rise = bclk_s & ~bclk_d_r;

    ////////////////////////////////////////////////////////////////////////////
    // Burst address arithmetic

    function automatic logic [ADDR_W-1:0] next_addr(
        input logic [ADDR_W-1:0] addr,
        input logic [2:0] len_sel
    );
        logic [ADDR_W-1:0] mask;
        logic [ADDR_W-1:0] inc;
        mask = '1;
        inc = addr + ADDR_W'(1);
        case (len_sel)
            mfr_pkg::BLEN_4: mask = ADDR_W'(3);
            mfr_pkg::BLEN_8: mask = ADDR_W'(7);
            mfr_pkg::BLEN_16: mask = ADDR_W'(15);
            mfr_pkg::BLEN_32: mask = ADDR_W'(31);
            default: mask = '1;
        endcase
        return (addr & ~mask) | (inc & mask);
    endfunction : next_addr

    ////////////////////////////////////////////////////////////////////////////
    // Configuration

    logic [2:0] lat_r;
    logic sync_mode;
    logic terminate;
    logic latch_req;

    // Latency register: out-of-range requests are ignored
    always_ff @(posedge I_CLOCK) begin
        if (I_SRST || !hrst_n_s || i_soft_reset) begin
            lat_r <= mfr_pkg::LAT_RESET;
        end else if (i_burst_latency_cycles >= mfr_pkg::LAT_MIN &&
                     i_burst_latency_cycles <= mfr_pkg::LAT_MAX) begin
            lat_r <= i_burst_latency_cycles;
        end
    end

    // Held in async mode while hard reset is active
    assign sync_mode = i_read_mode_select & hrst_n_s;

    assign terminate = ce_n_s | ~hrst_n_s | i_soft_reset | ~we_n_s;
    assign latch_req = ~adv_n_s & we_n_s;

    ////////////////////////////////////////////////////////////////////////////
    // Read sequencer

    mfr_pkg::mfr_state_type state_r;
    logic [2:0] edge_cnt_r;
    logic [ADDR_W-1:0] addr_r;
    logic rdy_r;

    always_ff @(posedge I_CLOCK) begin
        if (I_SRST || terminate) begin
            state_r <= mfr_pkg::ST_IDLE;
            edge_cnt_r <= 3'h0;
        end else if (latch_req && (bclk_rise || state_r != mfr_pkg::ST_LAT)) begin
            // Strobe held low after the latch edge waits for the next clock
            edge_cnt_r <= 3'h0;
            if (sync_mode && bclk_rise) begin
                state_r <= mfr_pkg::ST_LAT;
            end else begin
                // First word comes out without waiting for latency
                state_r <= mfr_pkg::ST_ASYNC;
            end
        end else begin
            case (state_r)
                mfr_pkg::ST_LAT: begin
                    if (bclk_rise) begin
                        edge_cnt_r <= edge_cnt_r + 3'h1;
                        if (edge_cnt_r + 3'h1 == lat_r) begin
                            state_r <= mfr_pkg::ST_BURST;
                        end
                    end
                end
                default: begin
                    state_r <= state_r;
                end
            endcase
        end
    end

    // Address latch and burst advance
    always_ff @(posedge I_CLOCK) begin
        if (I_SRST) begin
            addr_r <= '0;
        end else if (!terminate && latch_req) begin
            addr_r <= dq_s[ADDR_W-1:0];
        end else if (!terminate && state_r == mfr_pkg::ST_BURST && bclk_rise) begin
            addr_r <= next_addr(addr_r, i_burst_length_select);
        end
    end

    // Ready pulse: one burst clock period, from the fetch edge
    always_ff @(posedge I_CLOCK) begin
        if (I_SRST || terminate || latch_req) begin
            rdy_r <= 1'b0;
        end else if (state_r == mfr_pkg::ST_LAT && bclk_rise &&
                     edge_cnt_r + 3'h1 == lat_r) begin
            rdy_r <= 1'b1;
        end else if (bclk_rise) begin
            rdy_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output stage

    logic [mfr_pkg::WORD_W-1:0] data_r;
    logic oe_r;

    always_ff @(posedge I_CLOCK) begin
        if (I_SRST) begin
            data_r <= '0;
            oe_r <= 1'b0;
        end else begin
            data_r <= i_mem_data;
            oe_r <= (state_r != mfr_pkg::ST_IDLE) && !ce_n_s && !oe_n_s &&
                    adv_n_s && !terminate;
        end
    end

    assign o_mem_addr = addr_r;
    assign o_data_lines = data_r;
    assign o_data_lines_oe = oe_r;
    assign o_data_valid_flag = rdy_r;

endmodule : mfr_read_port

// [bench/mfr_read_port_props.sv]
/*
 * Concurrent checks on the pins of the flash read port.
 * Assumes binding to mfr_read_port, all pins seen through its synchronisers.
 */
`timescale 1ns/100ps

module mfr_read_port_props #(
    parameter int ADDR_W = 16
) (
    input wire logic I_CLOCK,
    input wire logic I_SRST,
    input wire logic i_chip_select_n,
    input wire logic i_write_strobe_n,
    input wire logic i_address_valid_strobe_n,
    input wire logic i_hard_reset_n,
    input wire logic i_soft_reset,
    input wire logic i_read_mode_select,
    input wire logic [ADDR_W-1:0] o_mem_addr,
    input wire logic o_data_lines_oe,
    input wire logic o_data_valid_flag
);
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_SRST);
    a_deselect_floats: assert property (i_chip_select_n [*5] |-> !o_data_lines_oe)
        else $error("bus driven while deselected");
    a_strobe_floats: assert property (!i_address_valid_strobe_n [*5] |-> !o_data_lines_oe)
        else $error("bus driven during address phase");
    a_write_ends: assert property (!i_write_strobe_n [*5] |-> !o_data_lines_oe)
        else $error("bus driven while write strobe low");
    a_hard_ends: assert property (!i_hard_reset_n [*5] |-> !o_data_valid_flag)
        else $error("ready during hard reset");
    a_soft_ends: assert property (i_soft_reset |-> ##[1:4] !o_data_valid_flag)
        else $error("ready survives soft reset");
    a_reset_idle: assert property (disable iff (1'b0) I_SRST |=>
        (o_mem_addr == '0 && !o_data_lines_oe && !o_data_valid_flag))
        else $error("outputs not idle after reset");
    a_ready_pulse: assert property ($rose(o_data_valid_flag) |->
        o_data_valid_flag [*8] ##[2:7] !o_data_valid_flag)
        else $error("ready pulse width wrong");
    a_ready_sync: assert property ($rose(o_data_valid_flag) |-> i_read_mode_select)
        else $error("ready in asynchronous mode");
    c_ready: cover property ($rose(o_data_valid_flag));
    c_drive: cover property ($rose(o_data_lines_oe));
    c_release: cover property ($fell(o_data_lines_oe));
endmodule : mfr_read_port_props

bind mfr_read_port mfr_read_port_props #(.ADDR_W(ADDR_W)) i_mfr_read_port_props (
    .I_CLOCK, .I_SRST, .i_chip_select_n, .i_write_strobe_n, .i_address_valid_strobe_n,
    .i_hard_reset_n, .i_soft_reset, .i_read_mode_select, .o_mem_addr, .o_data_lines_oe,
    .o_data_valid_flag);

// [bench/mfr_host.sv]
/*
 * Host burst clock source.
 * Assumes the bench raises i_run only for the length of a burst.
 */
`timescale 1ns/100ps

module mfr_host (
    input wire logic i_run,
    output logic o_burst_clock
);
    // 8 MHz, stands low between bursts; phase kept off the core clock edges
    initial begin
        o_burst_clock = 1'b0;
        #0.5;
        forever #62.5 o_burst_clock = i_run ? ~o_burst_clock : 1'b0;
    end
endmodule : mfr_host

// [bench/mfr_read_port_tb.sv]
/*
 * Self-checking bench of the flash read port.
 * Assumes a bench array model answering one cycle after the address.
 */
`timescale 1ns/100ps

module mfr_read_port_tb;
    logic clk = 0, srst = 1, ce_n = 1, oe_n = 1, we_n = 1, adv_n = 1, hrst_n = 1;
    logic run = 0, rm = 0, srs = 0, bclk, oe, vld;
    logic [2:0] lat = 3'h4, blen = 3'h0;
    logic [15:0] dq = 16'h0, mem, maddr, dout;
    int errors = 0, tests_run = 0;
    always #5 clk = ~clk;
    always_ff @(posedge clk) mem <= maddr ^ 16'h5A3C;
    mfr_host i_mfr_host (.i_run(run), .o_burst_clock(bclk));
    mfr_read_port i_mfr_read_port (.I_CLOCK(clk), .I_SRST(srst), .i_chip_select_n(ce_n),
        .i_output_enable_n(oe_n), .i_write_strobe_n(we_n), .i_address_valid_strobe_n(adv_n),
        .i_hard_reset_n(hrst_n), .i_burst_clock(bclk), .i_data_lines(oe ? dout : dq),
        .i_read_mode_select(rm), .i_burst_latency_cycles(lat), .i_burst_length_select(blen),
        .i_soft_reset(srs), .i_mem_data(mem), .o_mem_addr(maddr), .o_data_lines(dout),
        .o_data_lines_oe(oe), .o_data_valid_flag(vld));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic pins(input logic c, input logic o, input logic a, input logic [15:0] d);
        @(posedge clk) #1;
        ce_n = c;
        oe_n = o;
        adv_n = a;
        dq = d;
    endtask : pins
    // Bounded wait for a burst clock edge of the given polarity
    task automatic bwait(input logic lvl);
        logic prev;
        int k;
        prev = bclk;
        k = 0;
        @(posedge clk or bclk);
        while (k < 40 && !(bclk === lvl && prev !== lvl)) begin
            prev = bclk;
            k++;
            @(posedge clk or bclk);
        end
        if (!(bclk === lvl && prev !== lvl)) begin
            errors++;
            $display("[FAIL] t=%0t burst clock stalled got=%h exp=%h", $time, bclk, lvl);
            stop_test();
        end
    endtask : bwait
    task automatic t_async(input logic [15:0] a);
        pins(0, 1, 0, a);
        repeat (6) @(posedge clk);
        pins(0, 0, 1, ~a);
        repeat (8) @(posedge clk);
        chk(oe, 1);
        chk(dout, a ^ 16'h5A3C);
        repeat (20) @(posedge clk);
        chk(dout, a ^ 16'h5A3C);
        pins(0, 1, 1, a);
        repeat (5) @(posedge clk);
        chk(oe, 0);
        pins(1, 1, 1, ~a);
    endtask : t_async
    task automatic t_clocked(input logic [15:0] a);
        pins(0, 1, 0, a);
        rm = 0;
        run = 1;
        bwait(1'b1);
        pins(0, 0, 1, ~a);
        repeat (2) bwait(1'b0);
        run = 0;
        chk(oe, 1);
        chk(dout, a ^ 16'h5A3C);
        chk(vld, 0);
        pins(1, 1, 1, a);
        repeat (5) @(posedge clk);
        chk(oe, 0);
    endtask : t_clocked
    task automatic t_burst(input logic [2:0] n, input logic [2:0] bl, input logic [15:0] a,
        input int words, input logic kill);
        logic [15:0] w;
        logic [15:0] mask;
        int lat_exp;
        w = a;
        mask = (bl == 3'h0) ? 16'hFFFF : (16'h4 << (bl - 3'h1)) - 16'h1;
        // Out-of-range latency is ignored, so the value after reset stands
        lat_exp = (n < mfr_pkg::LAT_MIN) ? int'(mfr_pkg::LAT_RESET) : int'(n);
        pins(0, 1, 0, a);
        lat = n;
        blen = bl;
        rm = 1;
        run = 1;
        bwait(1'b1);
        pins(0, 0, 1, ~a);
        repeat (lat_exp) bwait(1'b1);
        bwait(1'b0);
        chk(vld, 1);
        chk(dout, a ^ 16'h5A3C);
        repeat (words) begin
            bwait(1'b0);
            w = (w & ~mask) | ((w + 16'h1) & mask);
            chk(vld, 0);
            chk(dout, w ^ 16'h5A3C);
        end
        run = 0;
        @(posedge clk) #1;
        we_n = !kill;
        repeat (6) @(posedge clk);
        chk(oe, !kill);
        pins(1, 1, 1, a);
        we_n = 1;
        repeat (5) @(posedge clk);
        chk(oe, 0);
    endtask : t_burst
    task automatic t_resets;
        pins(0, 1, 0, 16'h0300);
        lat = 3'h0;
        repeat (6) @(posedge clk);
        pins(0, 0, 1, 16'h0300);
        repeat (8) @(posedge clk);
        chk(oe, 1);
        @(posedge clk) #1;
        srs = 1;
        @(posedge clk) #1;
        srs = 0;
        repeat (2) @(posedge clk);
        chk(oe, 0);
        #1 hrst_n = 0;
        repeat (6) @(posedge clk);
        #1 hrst_n = 1;
        chk(vld, 0);
        chk(oe, 0);
        pins(1, 1, 1, 16'h0300);
    endtask : t_resets
    task automatic stop_test;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk);
        #1 srst = 0;
        chk(oe, 0);
        t_async(16'h0123);
        t_burst(3'h4, 3'h1, 16'h0201, 4, 0);
        t_burst(3'h3, 3'h0, 16'hFFFE, 3, 0);
        t_burst(3'h7, 3'h4, 16'h021E, 3, 0);
        t_burst(3'h6, 3'h3, 16'hF00E, 2, 0);
        t_burst(3'h5, 3'h2, 16'hF006, 2, 1);
        t_resets();
        t_burst(3'h0, 3'h1, 16'h0300, 2, 0);
        t_clocked(16'h0305);
        t_async(16'hF221);
        stop_test();
    end
endmodule : mfr_read_port_tb
